// ==== hw/vcs_cfg.svh ====
`ifndef VCS_CFG_SVH
`define VCS_CFG_SVH

// Register locations, decoded from the low address byte only.
`define VCS_LOC_IO_MODE 8'h00
`define VCS_LOC_DUMMY 8'h01
`define VCS_LOC_DRIVE 8'h03
`define VCS_LOC_ADDR_BYTES 8'h05
`define VCS_LOC_XIP 8'h06
`define VCS_LOC_WRAP 8'h07
`define VCS_LOC_PATTERN 8'h0a
`define VCS_LOC_ECC_CTRL 8'h0b
`define VCS_LOC_ERR_FLAGS 8'h0c
`define VCS_LOC_ADDR_LOW 8'h0d
`define VCS_LOC_ADDR_MLOW 8'h0e
`define VCS_LOC_ADDR_MHIGH 8'h0f
`define VCS_LOC_ADDR_HIGH 8'h10
`define VCS_LOC_BANK 8'h11

// Reset values.
`define VCS_ERASED 8'hff
`define VCS_PATTERN_RST 8'h55
`define VCS_FLAGS_RST 8'h00
`define VCS_ADDR_RST 8'h00

// Legal settings of the byte-wide fields.
`define VCS_IO_XSPI 8'hff
`define VCS_IO_XSPI_NOSTB 8'hdf
`define VCS_IO_ODDR 8'he7
`define VCS_IO_ODDR_NOSTB 8'hc7
`define VCS_DUMMY_MAX 8'h1f

// Field positions.
`define VCS_ECC_ON_N_BIT 0
`define VCS_ERR_TYPE_BIT 2
`define VCS_REPROG_BIT 7
`define VCS_TALLY_HI 6
`define VCS_TALLY_LO 3
`define VCS_UNCORR_BIT 2
`define VCS_PARITY_BIT 1
`define VCS_CRC_BIT 0
`define VCS_TALLY_MAX 4'hf
`define VCS_BANK_IDLE 4'h0
`define VCS_BANK_LOW_BASE 2'b01
`define VCS_BANK_HIGH_BASE 2'b11

`endif

// ==== hw/vcs_pkg.sv ====
package vcs_pkg;
  typedef logic [7:0] vcs_byte_t;
  typedef logic [2:0] vcs_bank_t;
  typedef enum logic [2:0] {
    VCS_ST_IDLE = 3'b001,
    VCS_ST_READ = 3'b010,
    VCS_ST_WRITE = 3'b100
  } vcs_state_t;
endpackage : vcs_pkg

// ==== hw/vcs_cfg_mem.sv ====
`timescale 1ns/100ps
`include "vcs_cfg.svh"

// Holds the writable configuration bytes; read data leave from a register.
module vcs_cfg_mem (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Write port
  input wire logic wr_en,
  input wire logic [2:0] wr_slot,
  input wire logic [7:0] wr_data,
  // Read port
  input wire logic [2:0] rd_slot,
  output logic [7:0] rd_data,
  // Direct view of every slot
  output logic [63:0] all_slots
);
  logic [7:0] mem_q [8];

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_slot
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          mem_q[gi] <= (gi == 6) ? `VCS_PATTERN_RST : `VCS_ERASED;
        end else if (wr_en && wr_slot == 3'(gi)) begin
          mem_q[gi] <= wr_data;
        end
      end
      assign all_slots[gi*8 +: 8] = mem_q[gi];
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_data <= `VCS_ERASED;
    end else begin
      rd_data <= mem_q[rd_slot];
    end
  end
endmodule : vcs_cfg_mem

// ==== hw/vcs_regs.sv ====
`timescale 1ns/100ps
`include "vcs_cfg.svh"

module vcs_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Strap: part boots in octal DDR
  input wire logic boot_octal,
  // Register command port from the command decoder
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [31:0] reg_addr,
  input wire vcs_pkg::vcs_byte_t reg_wdata,
  output vcs_pkg::vcs_byte_t reg_rdata,
  output logic reg_rvalid,
  // Write enable latch and flag status interaction
  input wire logic wel_in,
  output logic wel_clear,
  output logic bad_setting_set,
  // Array events
  input wire logic pe_active,
  input wire vcs_pkg::vcs_bank_t pe_bank,
  input wire logic ecc_corr_evt,
  input wire logic ecc_dbl_evt,
  input wire logic [31:0] ecc_evt_addr,
  input wire logic reprog_evt,
  input wire logic parity_err_evt,
  input wire logic crc_err_evt,
  // Configuration outputs
  output logic ecc_on_n,
  output logic error_type_select,
  output vcs_pkg::vcs_byte_t io_mode,
  output vcs_pkg::vcs_byte_t dummy_cycles,
  output logic err_event
);
  import vcs_pkg::*;

  vcs_state_t state_q;
  vcs_byte_t loc_q;
  vcs_byte_t wdata_q;
  logic strap_q;
  logic reprog_q;
  logic uncorr_q;
  logic parity_q;
  logic crc_q;
  logic [3:0] tally_q;
  logic captured_q;
  logic [27:0] chunk_q;
  logic [3:0] bank_q;
  logic mem_wr;
  logic [2:0] mem_wslot;
  logic [2:0] mem_rslot;
  vcs_byte_t mem_rdata;
  logic [63:0] slots;
  logic legal;
  logic [2:0] slot;
  logic stored;
  logic sel_evt;
  vcs_byte_t direct_d;
  vcs_byte_t direct_q;
  logic [3:0] cur_info;
  logic [3:0] req_info;
  vcs_byte_t req_loc;
  vcs_byte_t rdata_d;
  logic strap_meta_q;
  logic strap_mid_q;
  logic strap_late_q;
  logic strap_done_q;

  // Maps a location to a storage slot; the top bit of the result says if it is stored.
  function automatic logic [3:0] slot_of(input vcs_byte_t loc);
    logic [3:0] r;
    r = 4'h0;
    if (loc == `VCS_LOC_IO_MODE) begin
      r = 4'h8;
    end else if (loc == `VCS_LOC_DUMMY) begin
      r = 4'h9;
    end else if (loc == `VCS_LOC_DRIVE) begin
      r = 4'ha;
    end else if (loc == `VCS_LOC_ADDR_BYTES) begin
      r = 4'hb;
    end else if (loc == `VCS_LOC_XIP) begin
      r = 4'hc;
    end else if (loc == `VCS_LOC_WRAP) begin
      r = 4'hd;
    end else if (loc == `VCS_LOC_PATTERN) begin
      r = 4'he;
    end else if (loc == `VCS_LOC_ECC_CTRL) begin
      r = 4'hf;
    end
    return r;
  endfunction : slot_of

  // Checks that a written value is a defined setting of its location.
  function automatic logic setting_ok(input vcs_byte_t loc, input vcs_byte_t v,
                                      input logic octal);
    logic ok;
    ok = 1'b0;
    if (loc == `VCS_LOC_IO_MODE) begin
      if (octal) begin
        ok = (v == `VCS_IO_XSPI) || (v == `VCS_IO_ODDR);
      end else begin
        ok = (v == `VCS_IO_XSPI) || (v == `VCS_IO_XSPI_NOSTB) ||
             (v == `VCS_IO_ODDR) || (v == `VCS_IO_ODDR_NOSTB);
      end
    end else if (loc == `VCS_LOC_DUMMY) begin
      ok = (v <= `VCS_DUMMY_MAX);
    end else if (loc == `VCS_LOC_DRIVE) begin
      ok = (v >= 8'hfc);
    end else if (loc == `VCS_LOC_ADDR_BYTES) begin
      ok = (v >= 8'hfe);
    end else if (loc == `VCS_LOC_XIP) begin
      ok = (v >= 8'hfe);
    end else if (loc == `VCS_LOC_WRAP) begin
      ok = (v >= 8'hfc);
    end else if (loc == `VCS_LOC_PATTERN) begin
      ok = 1'b1;
    end else if (loc == `VCS_LOC_ECC_CTRL) begin
      ok = v[7]; // Bit 7 is reserved and must stay one.
    end
    return ok;
  endfunction : setting_ok

  // The strap pin is not timed to clk, so it passes three flops before it is used.
  // The chain runs through reset so that the pin has settled when reset is released.
  always_ff @(posedge clk) begin
    strap_meta_q <= boot_octal;
    strap_mid_q <= strap_meta_q;
    strap_late_q <= strap_mid_q;
  end

  // The strap is taken once after reset, when the last two flops agree, and then kept.
  // Holding it stops a pin glitch from changing which I/O modes are refused in mid-run.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      strap_q <= 1'b0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q && strap_mid_q == strap_late_q) begin
      strap_q <= strap_late_q;
      strap_done_q <= 1'b1;
    end
  end

  // Command sequencing: a command is taken in idle and completes one cycle later.
  // A request in the cycle after a take is ignored, so the host spaces its requests.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= VCS_ST_IDLE;
      loc_q <= 8'h00;
      wdata_q <= 8'h00;
    end else begin
      case (state_q)
        VCS_ST_IDLE: begin
          if (reg_rd) begin
            state_q <= VCS_ST_READ;
            loc_q <= reg_addr[7:0];
          end else if (reg_wr) begin
            state_q <= VCS_ST_WRITE;
            loc_q <= reg_addr[7:0];
            wdata_q <= reg_wdata;
          end
        end
        VCS_ST_READ: begin
          state_q <= VCS_ST_IDLE;
        end
        VCS_ST_WRITE: begin
          state_q <= VCS_ST_IDLE;
        end
        default: begin
          state_q <= VCS_ST_IDLE;
        end
      endcase
    end
  end

  // Only the low address byte reaches the decoders; the upper bytes are ignored.
  assign req_loc = reg_addr[7:0];
  assign cur_info = slot_of(loc_q);
  assign req_info = slot_of(req_loc);
  assign slot = cur_info[2:0];
  assign stored = cur_info[3];
  assign legal = stored && setting_ok(loc_q, wdata_q, strap_q);
  // A write without the latch is dropped quietly and raises no flag.
  assign mem_wr = (state_q == VCS_ST_WRITE) && wel_in && legal;
  assign mem_wslot = slot;
  assign mem_rslot = req_info[2:0];

  // A refused setting leaves the byte alone, raises the flag and drops the latch.
  assign bad_setting_set = (state_q == VCS_ST_WRITE) && wel_in && !legal;
  assign wel_clear = (state_q == VCS_ST_WRITE);

  vcs_cfg_mem u_mem (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(mem_wr),
    .wr_slot(mem_wslot),
    .wr_data(wdata_q),
    .rd_slot(mem_rslot),
    .rd_data(mem_rdata),
    .all_slots(slots)
  );

  assign io_mode = slots[7:0];
  assign dummy_cycles = slots[15:8];
  assign ecc_on_n = slots[56 + `VCS_ECC_ON_N_BIT];
  assign error_type_select = slots[56 + `VCS_ERR_TYPE_BIT];

  // Captured event type follows the select bit; only meaningful with ECC on.
  assign sel_evt = !ecc_on_n && (error_type_select ? ecc_dbl_evt : ecc_corr_evt);
  assign err_event = sel_evt;

  // Status flags are set by hardware and cleared only by reset, never by a read.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reprog_q <= 1'b0;
    end else if (reprog_evt && !ecc_on_n) begin
      reprog_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      uncorr_q <= 1'b0;
    end else if (ecc_dbl_evt && !ecc_on_n) begin
      uncorr_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      parity_q <= 1'b0;
    end else if (parity_err_evt) begin
      parity_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      crc_q <= 1'b0;
    end else if (crc_err_evt) begin
      crc_q <= 1'b1;
    end
  end

  // Saturating rather than wrapping keeps a long run of corrections from reading as few.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tally_q <= 4'h0;
    end else if (ecc_corr_evt && !ecc_on_n && tally_q != `VCS_TALLY_MAX) begin
      tally_q <= tally_q + 4'h1;
    end
  end

  // Only the first selected event is captured; later ones leave the address alone.
  // The low four address bits fall inside one chunk, so they are not kept.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      captured_q <= 1'b0;
      chunk_q <= 28'h0000000;
    end else if (sel_evt && !captured_q) begin
      captured_q <= 1'b1;
      chunk_q <= ecc_evt_addr[31:4];
    end
  end

  // Bank status trails the busy inputs by one cycle; a read shows that registered view.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bank_q <= `VCS_BANK_IDLE;
    end else if (pe_active && pe_bank[2]) begin
      bank_q <= {`VCS_BANK_HIGH_BASE, pe_bank[1:0]};
    end else if (pe_active) begin
      bank_q <= {`VCS_BANK_LOW_BASE, pe_bank[1:0]};
    end else begin
      bank_q <= `VCS_BANK_IDLE;
    end
  end

  // Status bytes are sampled into a register alongside the memory read.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      direct_q <= `VCS_ERASED;
    end else begin
      direct_q <= direct_d;
    end
  end

  // Any location not decoded here falls through to all ones.
  always_comb begin
    direct_d = `VCS_ERASED;
    if (req_loc == `VCS_LOC_ERR_FLAGS) begin
      direct_d = {reprog_q, tally_q, uncorr_q, parity_q, crc_q};
    end else if (req_loc == `VCS_LOC_ADDR_LOW) begin
      direct_d = {chunk_q[3:0], 4'h0};
    end else if (req_loc == `VCS_LOC_ADDR_MLOW) begin
      direct_d = chunk_q[11:4];
    end else if (req_loc == `VCS_LOC_ADDR_MHIGH) begin
      direct_d = chunk_q[19:12];
    end else if (req_loc == `VCS_LOC_ADDR_HIGH) begin
      direct_d = chunk_q[27:20];
    end else if (req_loc == `VCS_LOC_BANK) begin
      direct_d = {4'h0, bank_q};
    end
  end

  // Both read sources were sampled at the taken edge, so either is ready now.
  always_comb begin
    rdata_d = reg_rdata;
    if (state_q == VCS_ST_READ && stored) begin
      rdata_d = mem_rdata;
    end else if (state_q == VCS_ST_READ) begin
      rdata_d = direct_q;
    end
  end

  // Read data: the memory for stored bytes, status otherwise, all ones if reserved.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= `VCS_ERASED;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= (state_q == VCS_ST_READ);
      reg_rdata <= rdata_d;
    end
  end
endmodule : vcs_regs

// ==== bench/vcs_regs_assertions.sv ====
`timescale 1ns/100ps
module vcs_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register command port
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [31:0] reg_addr,
  input wire vcs_pkg::vcs_byte_t reg_rdata,
  input wire logic reg_rvalid,
  input wire logic wel_in,
  input wire logic wel_clear,
  input wire logic bad_setting_set,
  // Array events
  input wire logic pe_active,
  input wire vcs_pkg::vcs_bank_t pe_bank,
  input wire logic ecc_corr_evt,
  input wire logic ecc_dbl_evt,
  // Configuration
  input wire logic ecc_on_n,
  input wire logic error_type_select,
  input wire vcs_pkg::vcs_byte_t io_mode,
  input wire vcs_pkg::vcs_byte_t dummy_cycles,
  input wire logic err_event
);
  import vcs_pkg::*;
  logic busy_q;
  logic take;
  logic [7:0] loc;
  logic [7:0] bank_code;
  // The cycle after a taken request ignores requests, so it is not a take.
  assign take = (reg_rd | reg_wr) & ~busy_q;
  assign loc = reg_addr[7:0];
  assign bank_code = pe_active ? {4'h0, pe_bank[2], 1'b1, pe_bank[1:0]} : 8'h00;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= take;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_rd_lat; take && reg_rd |-> ##1 !reg_rvalid ##1 reg_rvalid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_rsv; take && reg_rd && (loc > 8'h11 || loc inside {8'h02, 8'h04, 8'h08, 8'h09})
    |-> ##2 reg_rdata == 8'hff; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved read not all ones");
  property p_bank; take && reg_rd && loc == 8'h11 |-> ##2 reg_rdata == $past(bank_code, 3);
  endproperty
  a_bank: assert property (p_bank) else $error("bank code wrong");
  property p_nib; take && reg_rd && loc == 8'h0d |-> ##2 reg_rdata[3:0] == 4'h0; endproperty
  a_nib: assert property (p_nib) else $error("low nibble not zero");
  property p_wel; take && reg_wr && !reg_rd |-> ##1 wel_clear; endproperty
  a_wel: assert property (p_wel) else $error("write enable not cleared");
  property p_ro; take && reg_wr && !reg_rd && wel_in && loc inside {[8'h0c:8'h11]}
    |-> ##1 bad_setting_set; endproperty
  a_ro: assert property (p_ro) else $error("status write not flagged");
  property p_keep; bad_setting_set |=> $stable(io_mode) && $stable(dummy_cycles)
    && $stable(ecc_on_n); endproperty
  a_keep: assert property (p_keep) else $error("refused write changed a setting");
  property p_err; err_event == (!ecc_on_n && (error_type_select ? ecc_dbl_evt : ecc_corr_evt));
  endproperty
  a_err: assert property (p_err) else $error("error event type wrong");
  property p_rst; $fell(sys_rst) |-> io_mode == 8'hff && dummy_cycles == 8'hff && ecc_on_n
    && error_type_select; endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
endmodule : vcs_chk

// ==== bench/vcs_host.sv ====
`timescale 1ns/100ps
// Host end of the register command port, one command at a time.
module vcs_host (
  // Clock
  input wire logic clk,
  // Register command port
  output logic reg_rd,
  output logic reg_wr,
  output logic [31:0] reg_addr,
  output vcs_pkg::vcs_byte_t reg_wdata
);
  import vcs_pkg::*;
  initial begin
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 32'h0;
    reg_wdata = 8'h0;
  end
  task automatic cmd(input logic wr, input logic [7:0] loc, input vcs_byte_t d);
    logic [31:0] r;
    r = $urandom();
    @(posedge clk);
    #2;
    reg_addr = {r[31:8], loc};
    reg_wdata = d;
    reg_rd = ~wr;
    reg_wr = wr;
    @(posedge clk);
    #2;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = ~d;
    @(posedge clk);
    #2;
    // Released lines change so that a stale address cannot pass for a held one.
    reg_addr = ~reg_addr;
    repeat (2) @(posedge clk);
    #2;
  endtask : cmd
endmodule : vcs_host

// ==== bench/tb.sv ====
`timescale 1ns/100ps
`define CHK(got, want) begin check_count++; if ((got) !== (want)) begin fails++; \
  $display("ERROR %0t: got %h want %h", $time, (got), (want)); end end
module tb;
  import vcs_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic boot_octal = 1'b0;
  logic wel_in = 1'b1;
  logic pe_active = 1'b0;
  vcs_bank_t pe_bank = 3'h0;
  logic [4:0] evt = 5'h0;
  logic [31:0] ecc_evt_addr = 32'h0;
  logic reg_rd, reg_wr, reg_rvalid, wel_clear, bad_setting_set;
  logic ecc_on_n, error_type_select, err_event;
  logic [31:0] reg_addr, first_a;
  vcs_byte_t reg_wdata, reg_rdata, io_mode, dummy_cycles, exp_v, d;
  vcs_byte_t exp_q[$];
  int fails = 0;
  int check_count = 0;
  int bad_cnt = 0;
  int clr_cnt = 0;
  always #12.5 clk = ~clk;
  vcs_host host (.clk(clk), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata));
  vcs_regs dut (.clk(clk), .sys_rst(sys_rst), .boot_octal(boot_octal), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .wel_in(wel_in), .wel_clear(wel_clear),
    .bad_setting_set(bad_setting_set), .pe_active(pe_active), .pe_bank(pe_bank),
    .ecc_corr_evt(evt[0]), .ecc_dbl_evt(evt[1]), .ecc_evt_addr(ecc_evt_addr),
    .reprog_evt(evt[2]), .parity_err_evt(evt[3]), .crc_err_evt(evt[4]),
    .ecc_on_n(ecc_on_n), .error_type_select(error_type_select), .io_mode(io_mode),
    .dummy_cycles(dummy_cycles), .err_event(err_event));
  always @(posedge clk) begin
    if (bad_setting_set === 1'b1) bad_cnt++;
    if (wel_clear === 1'b1) clr_cnt++;
    if (reg_rvalid === 1'b1) begin
      if (exp_q.size() > 0) begin
        exp_v = exp_q.pop_front();
        `CHK(reg_rdata, exp_v)
      end else `CHK(1'b0, 1'b1)
    end
  end
  task automatic rd(input logic [7:0] a, input vcs_byte_t e);
    exp_q.push_back(e);
    host.cmd(1'b0, a, 8'h00);
  endtask : rd
  task automatic pulse(input int k, input logic [31:0] a);
    @(posedge clk);
    #2;
    evt = 5'h1 << k;
    ecc_evt_addr = a;
    @(posedge clk);
    #2;
    evt = 5'h0;
    ecc_evt_addr = ~a;
  endtask : pulse
  function automatic vcs_byte_t rst_val(input logic [7:0] a);
    if (a == 8'h0a) return 8'h55;
    if (a >= 8'h0c && a <= 8'h11) return 8'h00;
    return 8'hff;
  endfunction : rst_val
  task automatic do_reset;
    @(posedge clk);
    #2;
    sys_rst = 1'b1;
    repeat (3) @(posedge clk);
    #2;
    sys_rst = 1'b0;
  endtask : do_reset
  task automatic tally_and_finish;
    $display("TB: checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    void'($urandom(32'h0c30bf3d));
    do_reset();
    for (int i = 0; i < 24; i++) rd(8'(i), rst_val(8'(i)));
    rd(8'hff, 8'hff);
    // A correction while ECC is still off must not count.
    pulse(0, $urandom());
    $display("TB: reset test done");
    d = 8'($urandom_range(31));
    host.cmd(1'b1, 8'h01, d);
    host.cmd(1'b1, 8'h00, 8'he7);
    host.cmd(1'b1, 8'h0b, 8'hfa);
    `CHK(dummy_cycles, d)
    `CHK(io_mode, 8'he7)
    `CHK(ecc_on_n, 1'b0)
    `CHK(error_type_select, 1'b0)
    host.cmd(1'b1, 8'h01, 8'h20);
    host.cmd(1'b1, 8'h0c, 8'h00);
    host.cmd(1'b1, 8'h12, 8'h00);
    wel_in = 1'b0;
    host.cmd(1'b1, 8'h01, 8'h05);
    wel_in = 1'b1;
    `CHK(bad_cnt, 3)
    `CHK(clr_cnt, 7)
    `CHK(dummy_cycles, d)
    rd(8'h01, d);
    $display("TB: write test done");
    first_a = $urandom();
    for (int i = 0; i < 3; i++) pulse(0, (i == 0) ? first_a : $urandom());
    rd(8'h0c, 8'h18);
    pulse(1, $urandom());
    rd(8'h0d, {first_a[7:4], 4'h0});
    rd(8'h0e, first_a[15:8]);
    rd(8'h0f, first_a[23:16]);
    rd(8'h10, first_a[31:24]);
    for (int i = 0; i < 14; i++) pulse(0, $urandom());
    pulse(3, 32'h0);
    rd(8'h0c, 8'h7e);
    pulse(2, 32'h0);
    pulse(4, 32'h0);
    rd(8'h0c, 8'hff);
    rd(8'h0d, {first_a[7:4], 4'h0});
    $display("TB: event test done");
    pe_active = 1'b1;
    for (int b = 0; b < 8; b++) begin
      pe_bank = 3'(b);
      rd(8'h11, {4'h0, pe_bank[2], 1'b1, pe_bank[1:0]});
    end
    pe_active = 1'b0;
    rd(8'h11, 8'h00);
    $display("TB: bank test done");
    boot_octal = 1'b1;
    do_reset();
    host.cmd(1'b1, 8'h00, 8'hdf);
    `CHK(io_mode, 8'hff)
    `CHK(bad_cnt, 4)
    rd(8'h0c, 8'h00);
    $display("TB: strap test done");
    // With the select bit set, a correction must not be captured but a detection must.
    host.cmd(1'b1, 8'h0b, 8'hfe);
    `CHK(error_type_select, 1'b1)
    `CHK(ecc_on_n, 1'b0)
    first_a = $urandom();
    pulse(0, ~first_a);
    pulse(1, first_a);
    rd(8'h10, first_a[31:24]);
    rd(8'h0d, {first_a[7:4], 4'h0});
    rd(8'h0c, 8'h0c);
    $display("TB: select test done");
    `CHK(exp_q.size(), 0)
    tally_and_finish();
  end
  initial begin
    #(25 * 5000);
    fails++;
    tally_and_finish();
  end
endmodule : tb
bind vcs_regs vcs_chk u_chk (.clk(clk), .sys_rst(sys_rst), .reg_rd(reg_rd), .reg_wr(reg_wr),
  .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .wel_in(wel_in),
  .wel_clear(wel_clear), .bad_setting_set(bad_setting_set), .pe_active(pe_active),
  .pe_bank(pe_bank), .ecc_corr_evt(ecc_corr_evt), .ecc_dbl_evt(ecc_dbl_evt),
  .ecc_on_n(ecc_on_n), .error_type_select(error_type_select), .io_mode(io_mode),
  .dummy_cycles(dummy_cycles), .err_event(err_event));
